// File: pbt_pkg.sv
// Shared constants for the parity bus transceiver
package pbt_pkg;
  // Word layout: eight data bits with the parity bit on top
  localparam int DATA_W          = 8;
  localparam int WORD_W          = 9;
  localparam int PAR_POS         = 8;
  localparam int DIR_COUNT       = 2;
  localparam int DIR_A_TO_B      = 0;
  localparam int DIR_B_TO_A      = 1;
  localparam int LOG_DEPTH       = 32;

  // Values after reset
  localparam logic [WORD_W-1:0] WORD_RST      = 9'h000;
  localparam logic              OE_RST        = 1'b0;
  localparam logic              FAULT_N_RST   = 1'b1;
  localparam logic              CLK_PREV_RST  = 1'b1;
  localparam logic              FLAG_RST      = 1'b0;

  // Storage mode of one direction in a given cycle
  typedef enum logic [2:0] {
    PBT_MODE_HOLD    = 3'b001,
    PBT_MODE_FOLLOW  = 3'b010,
    PBT_MODE_CAPTURE = 3'b100
  } pbt_mode_t;
endpackage : pbt_pkg

// File: pbt_transceiver.sv
// Parity bus transceiver core with capture log FIFO
//
// Behaviour
// - Parity enable low turns parity on; high gives plain 9-bit transceiver.
// - Port B driven only with its drive enable low; port A likewise.
// - Transparent enable high passes input straight to the output.
// - Latch off, capture enable low: store input on that clock's rising edge.
// - Latch off, capture enable high: clock edges ignored, output held.
// - Latch off, clock steady low: output keeps its earlier level.
// - Clock high when latch closed: held value valid only if clock was low.
// - B-to-A path mirrors A-to-B using its own controls.
// - Only A-to-B driving: check A, generate on B, B fault pin floats.
// - Only B-to-A driving: check B, generate on A, A fault pin floats.
// - Neither driving: check both ports, both parity pins are inputs.
// - Both driving: generate parity on both pins, both fault pins float.
// - Parity off: stored words cross when enabled, else ports isolated.
// - Sense low: fault high for even ones count, low for odd.
// - Sense high: fault high for odd ones count, low for even.
// - Generated bit is even parity of data, inverted by sense high.
// - Parity covers only the eight data bits of each group.
// - Data is never inverted on its way through.

module pbt_fifo
  import pbt_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = LOG_DEPTH
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);

  generate
    if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_param
      $error("pbt_fifo needs WIDTH >= 1 and DEPTH a power of two >= 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [0:DEPTH-1];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             in_ready_q;
  logic             out_valid_q;

  wire push = in_valid_i & in_ready_q;
  wire pop  = out_ready_i & out_valid_q;

  assign count_d     = count_q + (AW + 1)'(push) - (AW + 1)'(pop);
  assign in_ready_o  = in_ready_q;
  assign out_valid_o = out_valid_q;
  assign out_data_o  = mem_q[rd_q];

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_q        <= '0;
      rd_q        <= '0;
      count_q     <= '0;
      in_ready_q  <= 1'b1;
      out_valid_q <= FLAG_RST;
    end else begin
      wr_q        <= push ? wr_q + AW'(1) : wr_q;
      rd_q        <= pop ? rd_q + AW'(1) : rd_q;
      count_q     <= count_d;
      in_ready_q  <= (count_d != DEPTH_CNT);
      out_valid_q <= (count_d != '0);
    end
  end
endmodule : pbt_fifo

module pbt_transceiver
  import pbt_pkg::*;
#(
  parameter int LOG_WORDS = LOG_DEPTH
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // Port A pins
  input  wire logic [DATA_W-1:0] a_data_i,
  output logic      [DATA_W-1:0] a_data_o,
  output logic                   a_data_oe_o,
  input  wire logic              a_side_parity_bit_i,
  output logic                   a_side_parity_bit_o,
  output logic                   a_side_parity_bit_oe_o,
  output logic                   a_side_fault_n_o,
  output logic                   a_side_fault_oe_o,
  // Port B pins
  input  wire logic [DATA_W-1:0] b_data_i,
  output logic      [DATA_W-1:0] b_data_o,
  output logic                   b_data_oe_o,
  input  wire logic              b_side_parity_bit_i,
  output logic                   b_side_parity_bit_o,
  output logic                   b_side_parity_bit_oe_o,
  output logic                   b_side_fault_n_o,
  output logic                   b_side_fault_oe_o,
  // Direction controls
  input  wire logic              a_to_b_clock_i,
  input  wire logic              b_to_a_clock_i,
  input  wire logic              a_to_b_transparent_en_i,
  input  wire logic              b_to_a_transparent_en_i,
  input  wire logic              a_to_b_capture_en_n_i,
  input  wire logic              b_to_a_capture_en_n_i,
  input  wire logic              a_to_b_drive_en_n_i,
  input  wire logic              b_to_a_drive_en_n_i,
  // Parity controls
  input  wire logic              parity_enable_n_i,
  input  wire logic              odd_sense_i,
  // Log of A-to-B captured words
  output logic      [WORD_W-1:0] log_data_o,
  output logic                   log_valid_o,
  input  wire logic              log_ready_i,
  output logic                   log_room_o
);
  generate
    if (LOG_WORDS < 2 || (LOG_WORDS & (LOG_WORDS - 1)) != 0) begin : g_bad_param
      $error("pbt_transceiver needs LOG_WORDS a power of two >= 2");
    end
  endgenerate

  function automatic logic gen_parity(input logic [DATA_W-1:0] data, input logic odd);
    gen_parity = (^data) ^ odd;
  endfunction

  // Fault pin level, low on a failed check
  function automatic logic check_ok(input logic [WORD_W-1:0] word, input logic odd);
    check_ok = ~((^word) ^ odd);
  endfunction

  logic [WORD_W-1:0] src_w  [0:DIR_COUNT-1];
  logic [WORD_W-1:0] out_q  [0:DIR_COUNT-1];
  logic [DIR_COUNT-1:0] le_w;
  logic [DIR_COUNT-1:0] cap_n_w;
  logic [DIR_COUNT-1:0] clk_w;
  logic [DIR_COUNT-1:0] drv_n_w;
  logic [DIR_COUNT-1:0] capture_w;
  logic [DIR_COUNT-1:0] oe_q;
  logic [DIR_COUNT-1:0] fault_n_q;
  logic [DIR_COUNT-1:0] fault_oe_q;

  // Index 0 is A to B (source pins on A), index 1 is B to A
  assign src_w[DIR_A_TO_B] = {a_side_parity_bit_i, a_data_i};
  assign src_w[DIR_B_TO_A] = {b_side_parity_bit_i, b_data_i};
  assign le_w    = {b_to_a_transparent_en_i, a_to_b_transparent_en_i};
  assign cap_n_w = {b_to_a_capture_en_n_i, a_to_b_capture_en_n_i};
  assign clk_w   = {b_to_a_clock_i, a_to_b_clock_i};
  assign drv_n_w = {b_to_a_drive_en_n_i, a_to_b_drive_en_n_i};

  // Parity functions on only while enable is low
  wire par_on = ~parity_enable_n_i;

  genvar d;
  generate
    // Both directions built from the same logic
    for (d = 0; d < DIR_COUNT; d++) begin : g_dir
      logic [WORD_W-1:0] store_q;
      logic [WORD_W-1:0] store_d;
      logic              clk_prev_q;
      pbt_mode_t         mode;
      logic              gen_bit;
      logic              par_out;
      logic              check_on;

      // Rising edge of this direction's own clock
      wire clk_rise = clk_w[d] & ~clk_prev_q;

      // Transparent enable wins over the clock
      // Capture enable high blocks the edge
      assign mode = le_w[d] ? PBT_MODE_FOLLOW :
                    (~cap_n_w[d] & clk_rise) ? PBT_MODE_CAPTURE : PBT_MODE_HOLD;
      assign capture_w[d] = (mode == PBT_MODE_CAPTURE);

      // Hold keeps the earlier level while the clock stands
      // Clock high at latch close just holds the last followed word
      always_comb begin
        case (mode)
          PBT_MODE_FOLLOW:  store_d = src_w[d];
          PBT_MODE_CAPTURE: store_d = src_w[d];
          PBT_MODE_HOLD:    store_d = store_q;
          default:          store_d = store_q;
        endcase
      end

      // Only the data bits feed the generator
      // Parity taken from the word driving the data pins
      assign gen_bit = gen_parity(store_d[DATA_W-1:0], odd_sense_i);
      // Parity off passes the stored parity bit through
      assign par_out = par_on ? gen_bit : store_d[PAR_POS];

      // Port d is checked only while its own pins are inputs
      // That is when the opposite direction is not driving it
      // Both checked when neither direction drives
      // Both fault pins float when both directions drive
      assign check_on = par_on & drv_n_w[DIR_COUNT-1-d];

      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          store_q       <= WORD_RST;
          clk_prev_q    <= CLK_PREV_RST;
          out_q[d]      <= WORD_RST;
          oe_q[d]       <= OE_RST;
          fault_n_q[d]  <= FAULT_N_RST;
          fault_oe_q[d] <= OE_RST;
        end else begin
          store_q       <= store_d;
          clk_prev_q    <= clk_w[d];
          out_q[d]      <= {par_out, store_d[DATA_W-1:0]};
          // Drive only while the active-low enable is low
          oe_q[d]       <= ~drv_n_w[d];
          // Sense input flips the expected count
          // Check sampled from the live pins every cycle
          fault_n_q[d]  <= check_on ? check_ok(src_w[d], odd_sense_i) : FAULT_N_RST;
          fault_oe_q[d] <= check_on;
        end
      end
    end
  endgenerate

  // Port B is fed by the A-to-B direction, port A by the B-to-A direction
  assign b_data_o               = out_q[DIR_A_TO_B][DATA_W-1:0];
  assign b_side_parity_bit_o    = out_q[DIR_A_TO_B][PAR_POS];
  assign b_data_oe_o            = oe_q[DIR_A_TO_B];
  assign b_side_parity_bit_oe_o = oe_q[DIR_A_TO_B];
  assign a_data_o               = out_q[DIR_B_TO_A][DATA_W-1:0];
  assign a_side_parity_bit_o    = out_q[DIR_B_TO_A][PAR_POS];
  assign a_data_oe_o            = oe_q[DIR_B_TO_A];
  assign a_side_parity_bit_oe_o = oe_q[DIR_B_TO_A];
  assign a_side_fault_n_o       = fault_n_q[DIR_A_TO_B];
  assign a_side_fault_oe_o      = fault_oe_q[DIR_A_TO_B];
  assign b_side_fault_n_o       = fault_n_q[DIR_B_TO_A];
  assign b_side_fault_oe_o      = fault_oe_q[DIR_B_TO_A];

  // Captures never stall for the log; a full log drops words, seen on log_room_o
  pbt_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (LOG_WORDS)
  ) u_log (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (capture_w[DIR_A_TO_B]),
    .in_data_i   (src_w[DIR_A_TO_B]),
    .in_ready_o  (log_room_o),
    .out_valid_o (log_valid_o),
    .out_data_o  (log_data_o),
    .out_ready_i (log_ready_i)
  );
endmodule : pbt_transceiver

// File: pbt_transceiver_props.sv
// Pin-level checks for the parity bus transceiver
module pbt_transceiver_props
  import pbt_pkg::*;
(
  input wire logic              core_clk_i, rst_i, a_to_b_clock_i, a_to_b_transparent_en_i,
  input wire logic              a_to_b_capture_en_n_i, a_to_b_drive_en_n_i, b_to_a_drive_en_n_i,
  input wire logic              parity_enable_n_i, odd_sense_i, a_side_parity_bit_i,
  input wire logic              b_data_oe_o, b_side_parity_bit_oe_o, a_data_oe_o,
  input wire logic              a_side_parity_bit_oe_o, b_side_parity_bit_o, a_side_fault_n_o,
  input wire logic              a_side_fault_oe_o, b_side_fault_oe_o,
  input wire logic [DATA_W-1:0] a_data_i, b_data_o
);
  logic live_q;
  // Outputs lag by one edge, so the edge just after reset still shows reset values
  always_ff @(posedge core_clk_i) live_q <= !rst_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i || !live_q);
  sequence s_closed;
    !a_to_b_transparent_en_i;
  endsequence
  sequence s_rise;
    s_closed ##0 !a_to_b_capture_en_n_i && $rose(a_to_b_clock_i);
  endsequence
  AST_B_DRIVE: assert property (
    b_data_oe_o == !$past(a_to_b_drive_en_n_i) && b_side_parity_bit_oe_o == b_data_oe_o)
    else $error("port B drive wrong");
  AST_A_DRIVE: assert property (
    a_data_oe_o == !$past(b_to_a_drive_en_n_i) && a_side_parity_bit_oe_o == a_data_oe_o)
    else $error("port A drive wrong");
  AST_FOLLOW: assert property (
    a_to_b_transparent_en_i |=> b_data_o == $past(a_data_i)) else $error("follow wrong");
  AST_HOLD: assert property (
    s_closed ##0 a_to_b_capture_en_n_i |=> $stable(b_data_o)) else $error("hold lost");
  AST_CAPTURE: assert property (
    s_rise |=> b_data_o == $past(a_data_i)) else $error("capture wrong");
  AST_FAULT_A: assert property (
    a_side_fault_n_o == (!a_side_fault_oe_o || ((^$past(a_data_i)) ^ $past(a_side_parity_bit_i)
    ^ !$past(odd_sense_i)))) else $error("port A fault wrong");
  AST_FAULT_B_OE: assert property (
    b_side_fault_oe_o == (!$past(parity_enable_n_i) && $past(a_to_b_drive_en_n_i)))
    else $error("port B fault enable wrong");
  AST_GEN_B: assert property (
    b_data_oe_o && !$past(parity_enable_n_i) |-> b_side_parity_bit_o == ((^b_data_o)
    ^ $past(odd_sense_i))) else $error("port B parity wrong");
endmodule // pbt_transceiver_props

bind pbt_transceiver pbt_transceiver_props u_props (.*);

// File: pbt_agent.sv
// Bus agent standing on one transceiver port
module pbt_agent
  import pbt_pkg::*;
(
  input  wire logic [WORD_W-1:0] word_i,
  input  wire logic [WORD_W-1:0] dev_word_i,
  input  wire logic              dev_data_oe_i,
  input  wire logic              dev_par_oe_i,
  output logic      [WORD_W-1:0] pin_o
);
  // Agent backs off while the device drives; it drives its own word_i level otherwise
  assign pin_o[DATA_W-1:0] = dev_data_oe_i ? dev_word_i[DATA_W-1:0] : word_i[DATA_W-1:0];
  assign pin_o[PAR_POS]    = dev_par_oe_i ? dev_word_i[PAR_POS] : word_i[PAR_POS];
endmodule // pbt_agent

// File: pbt_transceiver_tb.sv
// Self-checking testbench for the parity bus transceiver
module pbt_transceiver_tb import pbt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0, rst_i = 1'b1, a_to_b_clock_i = 1'b0, b_to_a_clock_i = 1'b0;
  logic a_to_b_transparent_en_i = 1'b0, b_to_a_transparent_en_i = 1'b0, log_ready_i = 1'b0;
  logic a_to_b_capture_en_n_i = 1'b1, b_to_a_capture_en_n_i = 1'b1, odd_sense_i = 1'b0;
  logic a_to_b_drive_en_n_i = 1'b1, b_to_a_drive_en_n_i = 1'b1, parity_enable_n_i = 1'b1;
  logic [DATA_W-1:0] a_data_i, a_data_o, b_data_i, b_data_o;
  logic a_side_parity_bit_i, a_side_parity_bit_o, b_side_parity_bit_i, b_side_parity_bit_o;
  logic a_data_oe_o, a_side_parity_bit_oe_o, a_side_fault_n_o, a_side_fault_oe_o, b_data_oe_o;
  logic b_side_parity_bit_oe_o, b_side_fault_n_o, b_side_fault_oe_o, log_valid_o, log_room_o;
  logic [WORD_W-1:0] log_data_o, a_pin, b_pin, a_word = 9'h000, b_word = 9'h000;
  int n_fail = 0, n_tests = 0, cycles = 0;

  always #4 core_clk_i = ~core_clk_i;
  pbt_transceiver dut (.*);
  pbt_agent agent_a (.word_i(a_word), .dev_word_i({a_side_parity_bit_o, a_data_o}),
    .dev_data_oe_i(a_data_oe_o), .dev_par_oe_i(a_side_parity_bit_oe_o), .pin_o(a_pin));
  pbt_agent agent_b (.word_i(b_word), .dev_word_i({b_side_parity_bit_o, b_data_o}),
    .dev_data_oe_i(b_data_oe_o), .dev_par_oe_i(b_side_parity_bit_oe_o), .pin_o(b_pin));
  assign {a_side_parity_bit_i, a_data_i} = a_pin;
  assign {b_side_parity_bit_i, b_data_i} = b_pin;

  task automatic chk(input string nm, input logic [WORD_W-1:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // One rise of a direction clock, then back low so the next rise is seen
  task automatic pulse(input bit dir);
    if (dir) begin
      b_to_a_clock_i = 1'b1;
    end else begin
      a_to_b_clock_i = 1'b1;
    end
    cyc(1);
    a_to_b_clock_i = 1'b0;
    b_to_a_clock_i = 1'b0;
    cyc(1);
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    cyc(20);
    rst_i = 1'b0;
    cyc(2);
    chk("oe", 9'h000, 9'({a_data_oe_o, b_data_oe_o}));
    a_to_b_drive_en_n_i = 1'b0;
    a_to_b_transparent_en_i = 1'b1;
    a_word = 9'h1a5;
    cyc(2);
    chk("follow", 9'h1a5, {b_side_parity_bit_o, b_data_o});
    chk("b oe", 9'h003, 9'({b_side_parity_bit_oe_o, b_data_oe_o}));
    a_to_b_transparent_en_i = 1'b0;
    a_word = 9'h0ff;
    pulse(0);
    chk("hold", 9'h1a5, {b_side_parity_bit_o, b_data_o});
    a_to_b_capture_en_n_i = 1'b0;
    pulse(0);
    chk("capture", 9'h0ff, {b_side_parity_bit_o, b_data_o});
    a_to_b_drive_en_n_i = 1'b1;
    b_to_a_drive_en_n_i = 1'b0;
    b_to_a_capture_en_n_i = 1'b0;
    b_word = 9'h13c;
    cyc(1);
    pulse(1);
    chk("mirror", 9'h13c, {a_side_parity_bit_o, a_data_o});
    parity_enable_n_i = 1'b0;
    b_to_a_drive_en_n_i = 1'b1;
    for (int i = 0; i < 8; i++) begin
      odd_sense_i = i[2];
      a_word = {i[0], i[1] ? 8'h07 : 8'h30};
      b_word = a_word;
      cyc(2);
      chk("faults", 9'({2'b11, {2{(^a_word) ~^ odd_sense_i}}, 2'b00}),
        9'({a_side_fault_oe_o, b_side_fault_oe_o, a_side_fault_n_o, b_side_fault_n_o,
        a_side_parity_bit_oe_o, b_side_parity_bit_oe_o}));
    end
    a_to_b_drive_en_n_i = 1'b0;
    a_word = 9'h003;
    odd_sense_i = 1'b1;
    pulse(0);
    chk("gen b", 9'h103, {b_side_parity_bit_o, b_data_o});
    chk("chk a", 9'h004, 9'({a_side_fault_oe_o, b_side_fault_oe_o, a_side_fault_n_o}));
    b_to_a_drive_en_n_i = 1'b0;
    odd_sense_i = 1'b0;
    cyc(2);
    chk("both", 9'h003, 9'({a_side_fault_oe_o, b_side_fault_oe_o, a_side_parity_bit_o,
      b_side_parity_bit_o, a_side_parity_bit_oe_o, b_side_parity_bit_oe_o}));
    a_to_b_drive_en_n_i = 1'b1;
    cyc(2);
    chk("chk b", 9'h006, 9'({a_side_fault_oe_o, b_side_fault_oe_o, b_side_fault_n_o,
      a_side_parity_bit_o}));
    rst_i = 1'b1;
    parity_enable_n_i = 1'b1;
    b_to_a_drive_en_n_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    // The clock history resets high, so a rise on the release edge would be missed
    cyc(1);
    // Far side stalls while the log overfills; the last word must be dropped
    for (int i = 0; i < 33; i++) begin
      a_word = 9'(i);
      pulse(0);
    end
    chk("room", 9'h001, 9'({log_room_o, log_valid_o}));
    for (int i = 0; i < 32; i++) begin
      chk("log", 9'(i), log_data_o);
      log_ready_i = 1'b1;
      cyc(1);
      log_ready_i = 1'b0;
      cyc(1);
    end
    chk("drained", 9'h002, 9'({log_room_o, log_valid_o}));
    report_and_stop();
  end
endmodule // pbt_transceiver_tb
